// file: hw/adcs_sequencer.sv
// Control and sequencing logic of a 10-bit successive-approximation converter.
//
// Overview of operation
// - Start bit clears itself once conversion begins.
// - Standby resets control registers, ignores writes.
// - Second control top two bits read undefined.
// - Low result register low nibble is meaningless.
// - Reading upper result clears done flag.
// - Busy set at start, cleared at end.
// - Software mode converts selected channel once.
// - Completion stores result, sets done, interrupts.
// - Repeat mode restarts same channel on completion.
// - Mode 00 halts at once, discards result.
// - New start clears done, keeps old result.
// - Standby aborts conversion and clears results.
// - No automatic restart after standby ends.
// - Software mode starts right after start write.
// - Standby disconnects the analog reference.
// - Ten result bits split upper eight, lower two.
// - Input disable cuts all analog inputs.
`timescale 1ns/1ps
`include "adcs_consts.svh"
module adcs_sequencer (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [11:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic standby_i,
  input wire logic [9:0] core_result_i,
  output logic sample_start_o,
  output logic [3:0] channel_o,
  output logic input_disable_o,
  output logic ref_on_o,
  output logic busy_o,
  output logic conv_done_irq_o
);

  adcs_pkg::adcs_seq_s st_ff;
  adcs_pkg::adcs_seq_s nxt_st;

  adcs_tmr_if tif ();

  logic wr_ctrl1;
  logic wr_ctrl2;
  logic rd_upper;
  logic halt_req;
  logic start_ok;

  // Initial state, used both by the reset and by every standby cycle.
  function automatic adcs_pkg::adcs_seq_s init_st();
    adcs_pkg::adcs_seq_s s;
    logic [7:0] c1;
    logic [7:0] c2;
    c1 = `ADCS_C1_RST;
    c2 = `ADCS_C2_RST;
    s = '0;
    s.state = adcs_pkg::ADCS_IDLE;
    // Fields are cut out by part-select so no bits are dropped silently.
    s.start = c1[`ADCS_C1_START];
    s.mode = c1[`ADCS_C1_MODE_HI:`ADCS_C1_MODE_LO];
    s.in_dis = c1[`ADCS_C1_INDIS];
    s.chan = c1[`ADCS_C1_CHAN_HI:`ADCS_C1_CHAN_LO];
    s.refon = c2[`ADCS_C2_REFON];
    s.fix1 = c2[`ADCS_C2_FIX1];
    s.ctime = c2[`ADCS_C2_TIME_HI:`ADCS_C2_TIME_LO];
    s.fix0 = c2[`ADCS_C2_FIX0];
    return s;
  endfunction

  // The timer counts each conversion; it shares this module's clock and reset.
  adcs_timer u_timer (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .tif(tif.tmr)
  );

  // Standby gates every write, so control registers cannot be set meanwhile.
  assign wr_ctrl1 = wr_i && !standby_i && (addr_i == `ADCS_OFF_CTRL1);
  assign wr_ctrl2 = wr_i && !standby_i && (addr_i == `ADCS_OFF_CTRL2);
  assign rd_upper = rd_i && (addr_i == `ADCS_OFF_RES_UP);

  // Writing the disable mode code stops a running conversion at once.
  assign halt_req = wr_ctrl1 &&
    (wdata_i[`ADCS_C1_MODE_HI:`ADCS_C1_MODE_LO] == `ADCS_MODE_OFF);

  // Only the software and repeat modes may launch a conversion.
  assign start_ok = (st_ff.mode == `ADCS_MODE_SW) || (st_ff.mode == `ADCS_MODE_RPT);

  // Next-state logic of the whole sequencer.
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.irq = 1'b0;
    nxt_st.smp = 1'b0;
    nxt_st.rdata = 8'h00;
    tif.start = 1'b0;
    tif.abort = 1'b0;
    tif.code = st_ff.ctime;

    // Read data are taken from the current state and stand one cycle later.
    if (rd_i)
    begin
      case (addr_i)
        `ADCS_OFF_CTRL1:
        begin
          nxt_st.rdata = {st_ff.start, st_ff.mode, st_ff.in_dis, st_ff.chan};
        end
        `ADCS_OFF_CTRL2:
        begin
          // The two top bits carry no state and simply read as zero.
          nxt_st.rdata = {2'h0, st_ff.refon, st_ff.fix1, st_ff.ctime, st_ff.fix0};
        end
        `ADCS_OFF_RES_LOW:
        begin
          // The low nibble has no defined content and is returned as zero.
          nxt_st.rdata = {st_ff.result[1:0], st_ff.done, st_ff.busy, 4'h0};
        end
        `ADCS_OFF_RES_UP:
        begin
          nxt_st.rdata = st_ff.result[9:2];
        end
        default:
        begin
          nxt_st.rdata = 8'h00;
        end
      endcase
    end

    // Reading the upper result consumes the done flag; a set below wins.
    if (rd_upper)
    begin
      nxt_st.done = 1'b0;
    end

    // Register writes; bit0 and bit4 of the second register are kept as written.
    if (wr_ctrl1)
    begin
      nxt_st.mode = wdata_i[`ADCS_C1_MODE_HI:`ADCS_C1_MODE_LO];
      nxt_st.in_dis = wdata_i[`ADCS_C1_INDIS];
      nxt_st.chan = wdata_i[`ADCS_C1_CHAN_HI:`ADCS_C1_CHAN_LO];
      // A start request while converting is dropped rather than queued.
      nxt_st.start = wdata_i[`ADCS_C1_START] && !st_ff.busy;
    end
    if (wr_ctrl2)
    begin
      nxt_st.refon = wdata_i[`ADCS_C2_REFON];
      nxt_st.fix1 = wdata_i[`ADCS_C2_FIX1];
      nxt_st.ctime = wdata_i[`ADCS_C2_TIME_HI:`ADCS_C2_TIME_LO];
      nxt_st.fix0 = wdata_i[`ADCS_C2_FIX0];
    end

    // Conversion sequencing.
    case (st_ff.state)
      adcs_pkg::ADCS_IDLE:
      begin
        if (st_ff.start)
        begin
          // The start bit is consumed whether or not the mode allows a start.
          nxt_st.start = 1'b0;
          if (start_ok && !halt_req)
          begin
            tif.start = 1'b1;
            nxt_st.smp = 1'b1;
            nxt_st.state = adcs_pkg::ADCS_CONV;
            nxt_st.busy = 1'b1;
            nxt_st.done = 1'b0;
          end
        end
      end
      adcs_pkg::ADCS_CONV:
      begin
        if (halt_req)
        begin
          // The partial result is thrown away and the registers keep the old one.
          tif.abort = 1'b1;
          nxt_st.state = adcs_pkg::ADCS_IDLE;
          nxt_st.busy = 1'b0;
        end
        else if (tif.done)
        begin
          // Result, done flag and interrupt all change on the same edge.
          nxt_st.result = core_result_i;
          nxt_st.done = 1'b1;
          nxt_st.irq = 1'b1;
          if (st_ff.mode == `ADCS_MODE_RPT)
          begin
            // Back-to-back restart of the same channel keeps busy high.
            tif.start = 1'b1;
            nxt_st.smp = 1'b1;
          end
          else
          begin
            nxt_st.state = adcs_pkg::ADCS_IDLE;
            nxt_st.busy = 1'b0;
          end
        end
      end
      default:
      begin
        nxt_st.state = adcs_pkg::ADCS_IDLE;
        nxt_st.busy = 1'b0;
      end
    endcase

    // Standby overrides everything: abort, reinitialise, drop reference and results.
    if (standby_i)
    begin
      tif.start = 1'b0;
      tif.abort = 1'b1;
      nxt_st = init_st();
      nxt_st.rdata = st_ff.rdata;
      if (rd_i)
      begin
        // Reads during standby see the reinitialised, idle converter.
        nxt_st.rdata = 8'h00;
        if (addr_i == `ADCS_OFF_CTRL1)
        begin
          nxt_st.rdata = `ADCS_C1_RST;
        end
        else if (addr_i == `ADCS_OFF_CTRL2)
        begin
          nxt_st.rdata = `ADCS_C2_RST & 8'h3F;
        end
      end
      else
      begin
        nxt_st.rdata = 8'h00;
      end
      // Nothing restarts when standby ends; the start bit is already cleared.
      nxt_st.start = 1'b0;
    end
  end

  // State register; a synchronous reset loads the initial state.
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      st_ff <= init_st();
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // Every output is a bare flip-flop of the state.
  assign rdata_o = st_ff.rdata;
  assign sample_start_o = st_ff.smp;
  assign channel_o = st_ff.chan;
  assign input_disable_o = st_ff.in_dis;
  assign ref_on_o = st_ff.refon;
  assign busy_o = st_ff.busy;
  assign conv_done_irq_o = st_ff.irq;

endmodule // adcs_sequencer

// file: hw/adcs_timer.sv
// Conversion timer that counts clock cycles for the selected conversion length.
`timescale 1ns/1ps
`include "adcs_consts.svh"
module adcs_timer (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  adcs_tmr_if.tmr tif
);

  adcs_pkg::adcs_tmr_s st_ff;
  adcs_pkg::adcs_tmr_s nxt_st;

  // Reserved codes fall back to the shortest length so a stray code never hangs.
  function automatic logic [10:0] cyc_of(input logic [2:0] code);
    case (code)
      3'h2: cyc_of = `ADCS_CYC_010;
      3'h3: cyc_of = `ADCS_CYC_011;
      3'h4: cyc_of = `ADCS_CYC_100;
      3'h5: cyc_of = `ADCS_CYC_101;
      3'h6: cyc_of = `ADCS_CYC_110;
      default: cyc_of = `ADCS_CYC_000;
    endcase
  endfunction

  // Completion is flagged in the last counted cycle of the conversion.
  assign tif.done = st_ff.run && (st_ff.cnt == st_ff.lim - 11'd1);

  // Start wins over the end of a run so repeat conversions follow back to back.
  always_comb
  begin
    nxt_st = st_ff;
    if (tif.abort)
    begin
      nxt_st.run = 1'b0;
    end
    else if (tif.start)
    begin
      nxt_st.run = 1'b1;
      nxt_st.cnt = '0;
      nxt_st.lim = cyc_of(tif.code);
    end
    else if (tif.done)
    begin
      nxt_st.run = 1'b0;
    end
    else if (st_ff.run)
    begin
      nxt_st.cnt = st_ff.cnt + 11'd1;
    end
  end

  // State register.
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

endmodule // adcs_timer

// file: include/adcs_consts.svh
// Register offsets, field positions, reset values and conversion counts of the sequencer.
`ifndef ADCS_CONSTS_SVH
`define ADCS_CONSTS_SVH

// Register offsets on the plain register port.
`define ADCS_ADDR_W 12
`define ADCS_OFF_CTRL1 12'hFDE
`define ADCS_OFF_CTRL2 12'hFDF
`define ADCS_OFF_RES_LOW 12'hFE0
`define ADCS_OFF_RES_UP 12'hFE1

// Field positions of conv_control_first.
`define ADCS_C1_START 7
`define ADCS_C1_MODE_HI 6
`define ADCS_C1_MODE_LO 5
`define ADCS_C1_INDIS 4
`define ADCS_C1_CHAN_HI 3
`define ADCS_C1_CHAN_LO 0

// Field positions of conv_control_second.
`define ADCS_C2_REFON 5
`define ADCS_C2_FIX1 4
`define ADCS_C2_TIME_HI 3
`define ADCS_C2_TIME_LO 1
`define ADCS_C2_FIX0 0

// Reset values of the two control registers.
`define ADCS_C1_RST 8'h00
`define ADCS_C2_RST 8'h00

// Conversion mode field codes.
`define ADCS_MODE_OFF 2'h0
`define ADCS_MODE_SW 2'h1
`define ADCS_MODE_RPT 2'h3

// Conversion lengths in clock cycles per time field code.
`define ADCS_CNT_W 11
`define ADCS_CYC_000 11'd39
`define ADCS_CYC_010 11'd78
`define ADCS_CYC_011 11'd156
`define ADCS_CYC_100 11'd312
`define ADCS_CYC_101 11'd624
`define ADCS_CYC_110 11'd1248

`endif

// file: include/adcs_pkg.sv
// Types shared by the conversion sequencer and its timer.
package adcs_pkg;

  // Sequencer states.
  typedef enum logic {
    ADCS_IDLE,
    ADCS_CONV
  } adcs_state_e;

  // Complete state of the sequencer.
  typedef struct packed {
    adcs_state_e state;
    logic start;
    logic [1:0] mode;
    logic in_dis;
    logic [3:0] chan;
    logic refon;
    logic fix1;
    logic [2:0] ctime;
    logic fix0;
    logic busy;
    logic done;
    logic [9:0] result;
    logic [7:0] rdata;
    logic irq;
    logic smp;
  } adcs_seq_s;

  // Complete state of the conversion timer.
  typedef struct packed {
    logic run;
    logic [10:0] cnt;
    logic [10:0] lim;
  } adcs_tmr_s;

endpackage

// file: include/adcs_tmr_if.sv
// Handshake between the sequencer and its conversion timer.
`timescale 1ns/1ps
interface adcs_tmr_if;
  logic start;
  logic abort;
  logic [2:0] code;
  logic done;

  // The sequencer drives the commands, the timer reports completion.
  modport ctl (output start, output abort, output code, input done);
  modport tmr (input start, input abort, input code, output done);
endinterface

// file: tb/adcs_core_model.sv
// Behavioural model of the analog sampling core and its input mux.
`timescale 1ns/1ps
module adcs_core_model (
  input wire logic ref_clk_i,
  input wire logic sample_start_i,
  input wire logic [3:0] channel_i,
  input wire logic input_disable_i,
  input wire logic [9:0] level_i,
  output logic [9:0] core_result_o
);
  initial core_result_o = 10'h000;
  // The pin is sampled when a conversion begins; a disabled mux reads zero.
  always @(posedge ref_clk_i)
    if (sample_start_i)
      core_result_o <= input_disable_i ? 10'h000 : level_i ^ {6'h00, channel_i};
endmodule // adcs_core_model

// file: tb/adcs_seq_chk.sv
// Port-level assertions for the conversion sequencer.
`timescale 1ns/1ps
module adcs_seq_chk (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [11:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic standby_i,
  input wire logic sample_start_o,
  input wire logic [3:0] channel_o,
  input wire logic input_disable_o,
  input wire logic ref_on_o,
  input wire logic busy_o,
  input wire logic conv_done_irq_o
);
  // One clock domain, so clock and reset are given once.
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic c1_wr;
  // Writes are dropped in standby, so only run-mode writes count.
  assign c1_wr = wr_i && addr_i == 12'hFDE && !standby_i;
  property p_go; sample_start_o |-> busy_o; endproperty
  property p_rst; sample_start_o |-> !$past(busy_o) || conv_done_irq_o; endproperty
  property p_irq; conv_done_irq_o |-> $past(busy_o) && !$past(conv_done_irq_o); endproperty
  property p_halt; c1_wr && wdata_i[6:5] == 2'h0 |=> !busy_o && !conv_done_irq_o; endproperty
  property p_chan;
    c1_wr && !busy_o |=> channel_o == $past(wdata_i[3:0])
      && input_disable_o == $past(wdata_i[4]);
  endproperty
  property p_stby;
    standby_i |=> (!busy_o && !ref_on_o && !sample_start_o) ##1 !sample_start_o;
  endproperty
  property p_idle; !rd_i |=> rdata_o == 8'h00; endproperty
  property p_low;
    rd_i && addr_i == 12'hFE0 && !standby_i |=> rdata_o[4:0] == {$past(busy_o), 4'h0};
  endproperty
  a_go: assert property (p_go) else $error("start without busy");
  a_rst: assert property (p_rst) else $error("start while busy");
  a_irq: assert property (p_irq) else $error("bad irq pulse");
  a_halt: assert property (p_halt) else $error("halt not immediate");
  a_chan: assert property (p_chan) else $error("channel not taken");
  a_stby: assert property (p_stby) else $error("standby not obeyed");
  a_idle: assert property (p_idle) else $error("stray read data");
  a_low: assert property (p_low) else $error("bad status bits");
  c_irq: cover property (conv_done_irq_o);
  c_rpt: cover property (sample_start_o && conv_done_irq_o);
  c_halt: cover property (c1_wr && wdata_i[6:5] == 2'h0 && busy_o);
endmodule // adcs_seq_chk
bind adcs_sequencer adcs_seq_chk u_adcs_seq_chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .standby_i(standby_i), .sample_start_o(sample_start_o), .channel_o(channel_o),
  .input_disable_o(input_disable_o), .ref_on_o(ref_on_o), .busy_o(busy_o),
  .conv_done_irq_o(conv_done_irq_o));

// file: tb/tb_top.sv
// Self-checking bench for the conversion sequencer.
`timescale 1ns/1ps
module tb_top;
  logic ref_clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, standby_i = 1'b0;
  logic [11:0] addr_i = 12'h000;
  logic [7:0] wdata_i = 8'h00;
  logic [9:0] lvl = 10'h000, core_result_i, prev, cur;
  logic [7:0] rdata_o;
  logic [3:0] channel_o, ch;
  logic sample_start_o, input_disable_o, ref_on_o, busy_o, conv_done_irq_o, ind;
  logic rd_seen = 1'b0;
  logic [2:0] code;
  logic [7:0] rd_q[$];
  int len_q[$];
  int err_count = 0, check_count = 0, cnt = 0, i;
  int cyc[8] = '{39, 39, 78, 156, 312, 624, 1248, 39};
  initial forever #12.5 ref_clk_i = ~ref_clk_i;
  adcs_sequencer u_adcs_sequencer (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .standby_i(standby_i),
    .core_result_i(core_result_i), .sample_start_o(sample_start_o), .channel_o(channel_o),
    .input_disable_o(input_disable_o), .ref_on_o(ref_on_o), .busy_o(busy_o),
    .conv_done_irq_o(conv_done_irq_o));
  adcs_core_model u_adcs_core_model (.ref_clk_i(ref_clk_i), .sample_start_i(sample_start_o),
    .channel_i(channel_o), .input_disable_i(input_disable_o), .level_i(lvl),
    .core_result_o(core_result_i));
  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // One strobe cycle, then a release edge, so no signal is assigned twice at one edge.
  task automatic bus(logic w, logic [11:0] a, logic [7:0] d);
    @(posedge ref_clk_i);
    wr_i <= w;
    rd_i <= !w;
    addr_i <= a;
    wdata_i <= d;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
  endtask
  task automatic rd(logic [11:0] a, logic [7:0] e);
    rd_q.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask
  task automatic wait_irq();
    int n;
    n = 0;
    do
    begin
      @(negedge ref_clk_i);
      n++;
    end
    while (conv_done_irq_o !== 1'b1 && n < 2000);
    chk("irq_seen", 1, n < 2000);
  endtask
  // Read data stand one cycle after the strobe; conversion length runs start to irq.
  always @(posedge ref_clk_i)
    rd_seen <= rd_i;
  always @(negedge ref_clk_i)
  begin
    cnt++;
    if (rd_seen)
      chk("rdata", rd_q.size() ? rd_q.pop_front() : 8'hXX, rdata_o);
    if (conv_done_irq_o === 1'b1)
      chk("conv_len", len_q.size() ? len_q.pop_front() : -1, cnt);
    if (sample_start_o === 1'b1)
      cnt = 0;
  end
  initial
  begin
    #(25 * 20000);
    err_count++;
    $display("CHECK FAILED watchdog exp finish got timeout");
    finish_test();
  end
  initial
  begin
    i = $urandom(72);
    repeat (8) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rd(12'hFDE, 8'h00);
    rd(12'hFDF, 8'h00);
    rd(12'hFE0, 8'h00);
    rd(12'hFE1, 8'h00);
    rd(12'hFFF, 8'h00);
    $display("test reset_values ended");
    prev = 10'h000;
    // Every time code; each upper result but the last is read only after the next start, so that start must clear done.
    for (i = 0; i < 8; i++)
    begin
      code = i;
      ch = $urandom_range(7);
      ind = (i == 5);
      lvl <= $urandom;
      bus(1'b1, 12'hFDF, {4'h3, code, 1'b0});
      rd(12'hFDF, {4'h3, code, 1'b0});
      len_q.push_back(cyc[i]);
      bus(1'b1, 12'hFDE, {3'h5, ind, ch});
      cur = ind ? 10'h000 : lvl ^ {6'h00, ch};
      rd(12'hFDE, {3'h1, ind, ch});
      @(negedge ref_clk_i);
      chk("channel", {ind, ch}, {input_disable_o, channel_o});
      rd(12'hFE0, {prev[1:0], 2'h1, 4'h0});
      rd(12'hFE1, prev[9:2]);
      wait_irq();
      rd(12'hFE0, {cur[1:0], 2'h2, 4'h0});
      prev = cur;
    end
    rd(12'hFE1, prev[9:2]);
    rd(12'hFE0, {prev[1:0], 2'h0, 4'h0});
    $display("test single_conversions ended");
    lvl <= $urandom;
    ch = $urandom_range(7);
    bus(1'b1, 12'hFDF, 8'h30);
    len_q.push_back(39);
    len_q.push_back(39);
    bus(1'b1, 12'hFDE, {4'hE, ch});
    cur = lvl ^ {6'h00, ch};
    wait_irq();
    wait_irq();
    rd(12'hFE0, {cur[1:0], 2'h3, 4'h0});
    bus(1'b1, 12'hFDE, {4'h0, ch});
    lvl <= ~lvl;
    repeat (60) @(posedge ref_clk_i);
    rd(12'hFE0, {cur[1:0], 2'h2, 4'h0});
    rd(12'hFE1, cur[9:2]);
    $display("test repeat_and_halt ended");
    // Standby mid-conversion; any late irq would find no expected length.
    bus(1'b1, 12'hFDF, 8'h32);
    bus(1'b1, 12'hFDE, 8'hA1);
    repeat (5) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk("ref_on_run", 1, ref_on_o);
    @(posedge ref_clk_i);
    standby_i <= 1'b1;
    bus(1'b1, 12'hFDF, 8'h3C);
    rd(12'hFDE, 8'h00);
    @(negedge ref_clk_i);
    chk("ref_on_stby", 0, ref_on_o);
    chk("busy_stby", 0, busy_o);
    standby_i <= 1'b0;
    rd(12'hFDF, 8'h00);
    rd(12'hFE0, 8'h00);
    rd(12'hFE1, 8'h00);
    repeat (100) @(posedge ref_clk_i);
    $display("test standby ended");
    finish_test();
  end
endmodule // tb_top
